// [fpio_pkg.sv]
// constants, register map and carrier types for the four-port parallel io block
// assumes a 32-bit avalon-mm slave port with byte addressing, one aligned word per register
package fpio_pkg;

    // ****************************************
    // register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [3:0] FPIO_IDX_PORT_A_DATA = 4'h0;
    localparam logic [3:0] FPIO_IDX_PORT_B_DATA = 4'h1;
    localparam logic [3:0] FPIO_IDX_PORT_C_DATA = 4'h2;
    localparam logic [3:0] FPIO_IDX_PORT_D_DATA = 4'h3;
    localparam logic [3:0] FPIO_IDX_PORT_A_DIR = 4'h4;
    localparam logic [3:0] FPIO_IDX_PORT_B_DIR = 4'h5;
    localparam logic [3:0] FPIO_IDX_PORT_C_DIR = 4'h6;
    localparam logic [3:0] FPIO_IDX_PORT_D_DIR = 4'h7;
    localparam logic [3:0] FPIO_IDX_LAMP_EN = 4'hc;

    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int FPIO_ADDR_W = 6;
    localparam int FPIO_PORT_W = 8;
    localparam int FPIO_PORTS = 4;
    localparam int FPIO_PINS = FPIO_PORT_W * FPIO_PORTS;
    localparam logic [31:0] FPIO_DIR_RESET = 32'h0000_0000;
    localparam logic [7:0] FPIO_LAMP_RESET = 8'h00;
    localparam logic [31:0] FPIO_RDATA_RESET = 32'h0000_0000;

    // pins that only ever pull low: second port bits 0..3, third port bits 6..7
    localparam logic [31:0] FPIO_OPEN_DRAIN_MASK = 32'h00c0_0f00;

    // first pin of each port inside the 32-bit pin vector
    localparam int FPIO_PORT_B_BASE = 8;
    localparam int FPIO_PORT_C_BASE = 16;
    localparam int FPIO_PORT_D_BASE = 24;

    // converter channel select width; channels 0..7 sit on the first port
    localparam int FPIO_ADC_SEL_W = 5;

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic read;
        logic write;
        logic [FPIO_ADDR_W-1:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } fpio_avm_req_t;

    typedef struct packed {
        logic two_wire_serial_enable;
        logic async_serial_enable;
        logic async_serial2_enable;
        logic spi_block_enable;
        logic second_ext_interrupt_mask;
        logic [7:0] timer_channel_edge_select;
        logic [7:0] keypad_input_enable_bits;
        logic [FPIO_ADC_SEL_W-1:0] converter_channel_select;
    } fpio_periph_en_t;

    typedef struct packed {
        logic [31:0] level;
        logic [31:0] enable;
    } fpio_drive_t;

    typedef enum logic [0:0] {
        FPIO_BUS_IDLE = 1'b0,
        FPIO_BUS_ACK = 1'b1
    } fpio_bus_state_t;

endpackage

// [fpio_top.sv]
// four eight-bit general-purpose ports with shared peripheral pins, avalon-mm register slave
// assumes pins and peripheral signals are synchronous to clk_in; pad logic resolves out/oe
//
// Contract
// - there are thirty-two two-way pins in four eight-bit ports, each with a data and a direction register.
// - each pin is an input or an output according to its own direction bit.
// - all first-port pins can feed the converter, and its channel select picks the one pin handed over.
// - each first-port pin has a lamp drive option enabled by its bit of a lamp register that resets to zero.
// - two-wire serial and both async serial pins only pull low as outputs and never drive high.
// - reset clears all direction bits so every pin comes up as an input.
// - a data read returns the latch for output pins and the live pin level for input pins.
// - a data write with byte lane 0 enabled updates the latch whatever the direction bit.
// - a peripheral enable that claims a pin overrides the port data and direction logic.
`timescale 1ns/1ps
module fpio_top (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire fpio_pkg::fpio_avm_req_t avm_req_in,
    output fpio_pkg::fpio_drive_t pin_drive_out,
    output logic [31:0] avm_readdata_out,
    output logic avm_waitrequest_out,
    input wire logic [31:0] pin_level_in,
    input wire fpio_pkg::fpio_periph_en_t periph_en_in,
    input wire fpio_pkg::fpio_drive_t periph_drive_in,
    output logic [31:0] periph_pin_level_out,
    output logic [7:0] adc_pin_claim_out,
    output logic [7:0] lamp_drive_out
);
    import fpio_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [31:0] dir;
        logic [7:0] lamp;
        fpio_bus_state_t bus;
        logic waitreq;
        logic [31:0] rdata;
        logic [31:0] pin_lvl;
        logic [31:0] pin_out;
        logic [31:0] pin_oe;
        logic [7:0] adc_claim;
        logic [7:0] lamp_out;
    } fpio_state_t;

    fpio_state_t state_reg;
    fpio_state_t state_next;
    logic [31:0] claim;
    logic [7:0] adc_sel;
    logic [3:0] word_idx;
    logic addr_hit;
    logic [31:0] rd_value;
    logic [31:0] gpio_view;
    logic [31:0] latch_reg;
    logic [31:0] latch_next;
    logic [FPIO_PORT_W-1:0] port_level [FPIO_PORTS];
    logic [FPIO_PORT_W-1:0] port_enable [FPIO_PORTS];
    logic [FPIO_PORT_W-1:0] port_view [FPIO_PORTS];
    logic [31:0] drv_level;
    logic [31:0] drv_enable;
    logic take_write;

    // ****************************************
    // pin ownership
    // ****************************************
    always_comb begin
        claim = 32'h0000_0000;
        adc_sel = 8'h00;
        // only codes 0..7 name a first-port pin; higher codes leave the port alone
        if (periph_en_in.converter_channel_select[4:3] == 2'b00) begin
            adc_sel[periph_en_in.converter_channel_select[2:0]] = 1'b1;
        end
        claim[7:0] = adc_sel;
        claim[FPIO_PORT_B_BASE+0] = periph_en_in.two_wire_serial_enable;
        claim[FPIO_PORT_B_BASE+1] = periph_en_in.two_wire_serial_enable;
        claim[FPIO_PORT_B_BASE+2] = periph_en_in.async_serial_enable;
        claim[FPIO_PORT_B_BASE+3] = periph_en_in.async_serial_enable;
        for (int k = 0; k < 4; k++) begin
            // a timer channel owns its pin for any edge/level setting other than zero
            claim[FPIO_PORT_B_BASE+4+k] = |periph_en_in.timer_channel_edge_select[2*k +: 2];
        end
        claim[FPIO_PORT_C_BASE+0] = ~periph_en_in.second_ext_interrupt_mask;
        claim[FPIO_PORT_C_BASE+5 -: 4] = {4{periph_en_in.spi_block_enable}};
        claim[FPIO_PORT_C_BASE+6] = periph_en_in.async_serial2_enable;
        claim[FPIO_PORT_C_BASE+7] = periph_en_in.async_serial2_enable;
        claim[FPIO_PORT_D_BASE +: 8] = periph_en_in.keypad_input_enable_bits;
    end

    // ****************************************
    // pad drive, one slice per port
    // ****************************************
    for (genvar g = 0; g < FPIO_PORTS; g++) begin : gen_port
        fpio_port_pads #(
            .PORT_W(FPIO_PORT_W),
            .OPEN_DRAIN(FPIO_OPEN_DRAIN_MASK[FPIO_PORT_W*g +: FPIO_PORT_W]),
            .HAS_ANALOG(g == 0)
        ) pads_u (
            .claim_in(claim[FPIO_PORT_W*g +: FPIO_PORT_W]),
            .analog_in(adc_sel),
            .latch_in(latch_reg[FPIO_PORT_W*g +: FPIO_PORT_W]),
            .dir_in(state_reg.dir[FPIO_PORT_W*g +: FPIO_PORT_W]),
            .pin_level_in(pin_level_in[FPIO_PORT_W*g +: FPIO_PORT_W]),
            .periph_level_in(periph_drive_in.level[FPIO_PORT_W*g +: FPIO_PORT_W]),
            .periph_enable_in(periph_drive_in.enable[FPIO_PORT_W*g +: FPIO_PORT_W]),
            .level_out(port_level[g]),
            .enable_out(port_enable[g]),
            .view_out(port_view[g])
        );
    end

    // the slices are gathered here so each pin vector has a single driver
    always_comb begin
        drv_level = 32'h0000_0000;
        drv_enable = 32'h0000_0000;
        gpio_view = 32'h0000_0000;
        for (int p = 0; p < FPIO_PORTS; p++) begin
            drv_level[FPIO_PORT_W*p +: FPIO_PORT_W] = port_level[p];
            drv_enable[FPIO_PORT_W*p +: FPIO_PORT_W] = port_enable[p];
            gpio_view[FPIO_PORT_W*p +: FPIO_PORT_W] = port_view[p];
        end
    end

    // ****************************************
    // register read view
    // ****************************************
    always_comb begin
        word_idx = avm_req_in.address[5:2];
        addr_hit = 1'b1;
        rd_value = FPIO_RDATA_RESET;
        if (word_idx == FPIO_IDX_PORT_A_DATA) begin
            rd_value[7:0] = gpio_view[7:0];
        end else if (word_idx == FPIO_IDX_PORT_B_DATA) begin
            rd_value[7:0] = gpio_view[FPIO_PORT_B_BASE +: 8];
        end else if (word_idx == FPIO_IDX_PORT_C_DATA) begin
            rd_value[7:0] = gpio_view[FPIO_PORT_C_BASE +: 8];
        end else if (word_idx == FPIO_IDX_PORT_D_DATA) begin
            rd_value[7:0] = gpio_view[FPIO_PORT_D_BASE +: 8];
        end else if (word_idx == FPIO_IDX_PORT_A_DIR) begin
            rd_value[7:0] = state_reg.dir[7:0];
        end else if (word_idx == FPIO_IDX_PORT_B_DIR) begin
            rd_value[7:0] = state_reg.dir[FPIO_PORT_B_BASE +: 8];
        end else if (word_idx == FPIO_IDX_PORT_C_DIR) begin
            rd_value[7:0] = state_reg.dir[FPIO_PORT_C_BASE +: 8];
        end else if (word_idx == FPIO_IDX_PORT_D_DIR) begin
            rd_value[7:0] = state_reg.dir[FPIO_PORT_D_BASE +: 8];
        end else if (word_idx == FPIO_IDX_LAMP_EN) begin
            rd_value[7:0] = state_reg.lamp;
        end else begin
            addr_hit = 1'b0;
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        state_next = state_reg;
        take_write = 1'b0;
        case (state_reg.bus)
            FPIO_BUS_IDLE: begin
                if (avm_req_in.read || avm_req_in.write) begin
                    // read data is captured here and held through the acknowledge cycle
                    state_next.bus = FPIO_BUS_ACK;
                    state_next.waitreq = 1'b0;
                    state_next.rdata = avm_req_in.read ? rd_value : FPIO_RDATA_RESET;
                end
            end
            FPIO_BUS_ACK: begin
                // the master samples waitrequest low at this edge; the write lands here
                take_write = avm_req_in.write && addr_hit && avm_req_in.byteenable[0];
                state_next.bus = FPIO_BUS_IDLE;
                state_next.waitreq = 1'b1;
            end
            default: begin
                state_next.bus = FPIO_BUS_IDLE;
                state_next.waitreq = 1'b1;
            end
        endcase
        if (take_write) begin
            if (word_idx == FPIO_IDX_PORT_A_DIR) begin
                state_next.dir[7:0] = avm_req_in.writedata[7:0];
            end else if (word_idx == FPIO_IDX_PORT_B_DIR) begin
                state_next.dir[FPIO_PORT_B_BASE +: 8] = avm_req_in.writedata[7:0];
            end else if (word_idx == FPIO_IDX_PORT_C_DIR) begin
                state_next.dir[FPIO_PORT_C_BASE +: 8] = avm_req_in.writedata[7:0];
            end else if (word_idx == FPIO_IDX_PORT_D_DIR) begin
                state_next.dir[FPIO_PORT_D_BASE +: 8] = avm_req_in.writedata[7:0];
            end else if (word_idx == FPIO_IDX_LAMP_EN) begin
                state_next.lamp = avm_req_in.writedata[7:0];
            end
        end
        state_next.pin_lvl = pin_level_in;
        state_next.pin_out = drv_level;
        state_next.pin_oe = drv_enable;
        state_next.adc_claim = adc_sel;
        // lamp drive only acts on a pin that is an output and not handed to the converter
        state_next.lamp_out = state_reg.lamp & state_reg.dir[7:0] & ~adc_sel;
    end

    // ****************************************
    // data latches
    // ****************************************
    // a write lands whatever the direction bit, so software can preload a pin before turning it
    always_comb begin
        latch_next = latch_reg;
        if (take_write) begin
            if (word_idx == FPIO_IDX_PORT_A_DATA) begin
                latch_next[7:0] = avm_req_in.writedata[7:0];
            end else if (word_idx == FPIO_IDX_PORT_B_DATA) begin
                latch_next[FPIO_PORT_B_BASE +: 8] = avm_req_in.writedata[7:0];
            end else if (word_idx == FPIO_IDX_PORT_C_DATA) begin
                latch_next[FPIO_PORT_C_BASE +: 8] = avm_req_in.writedata[7:0];
            end else if (word_idx == FPIO_IDX_PORT_D_DATA) begin
                latch_next[FPIO_PORT_D_BASE +: 8] = avm_req_in.writedata[7:0];
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg.dir <= FPIO_DIR_RESET;
            state_reg.lamp <= FPIO_LAMP_RESET;
            state_reg.bus <= FPIO_BUS_IDLE;
            state_reg.waitreq <= 1'b1;
            state_reg.rdata <= FPIO_RDATA_RESET;
            state_reg.pin_lvl <= 32'h0000_0000;
            state_reg.pin_out <= 32'h0000_0000;
            state_reg.pin_oe <= 32'h0000_0000;
            state_reg.adc_claim <= 8'h00;
            state_reg.lamp_out <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    // the latches sit outside the state record so that no reset ever reaches them
    always_ff @(posedge clk_in) begin
        latch_reg <= latch_next;
    end

    // ****************************************
    // outputs
    // ****************************************

    assign pin_drive_out.level = state_reg.pin_out;
    assign pin_drive_out.enable = state_reg.pin_oe;
    assign avm_readdata_out = state_reg.rdata;
    assign avm_waitrequest_out = state_reg.waitreq;
    assign periph_pin_level_out = state_reg.pin_lvl;
    assign adc_pin_claim_out = state_reg.adc_claim;
    assign lamp_drive_out = state_reg.lamp_out;

endmodule

// ****************************************
// one eight-pin port: pad drive and read view
// ****************************************
module fpio_port_pads #(
    parameter int PORT_W = 8,
    parameter logic [PORT_W-1:0] OPEN_DRAIN = '0,
    parameter bit HAS_ANALOG = 1'b0
) (
    input wire logic [PORT_W-1:0] claim_in,
    input wire logic [PORT_W-1:0] analog_in,
    input wire logic [PORT_W-1:0] latch_in,
    input wire logic [PORT_W-1:0] dir_in,
    input wire logic [PORT_W-1:0] pin_level_in,
    input wire logic [PORT_W-1:0] periph_level_in,
    input wire logic [PORT_W-1:0] periph_enable_in,
    output logic [PORT_W-1:0] level_out,
    output logic [PORT_W-1:0] enable_out,
    output logic [PORT_W-1:0] view_out
);
    always_comb begin
        level_out = '0;
        enable_out = '0;
        // output pins reflect the latch, inputs the live pad level
        // the view ignores peripheral claims; software sees latch or pad by direction
        view_out = (dir_in & latch_in) | (~dir_in & pin_level_in);
        for (int i = 0; i < PORT_W; i++) begin
            if (claim_in[i]) begin
                level_out[i] = periph_level_in[i];
                enable_out[i] = periph_enable_in[i];
            end else begin
                level_out[i] = latch_in[i];
                enable_out[i] = dir_in[i];
            end
            // the converter input must never see a driven pad
            if (HAS_ANALOG && analog_in[i]) begin
                enable_out[i] = 1'b0;
            end
            if (OPEN_DRAIN[i]) begin
                // a high becomes release so the external pull-up sets the level
                enable_out[i] = enable_out[i] & ~level_out[i];
                level_out[i] = 1'b0;
            end
        end
    end
endmodule

// [fpio_checker_assertions.sv]
// concurrent checks on the ports of the four-port io block
// assumes it is bound to fpio_top; one clock domain, async active-low reset
`timescale 1ns/1ps
module fpio_checker (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire fpio_pkg::fpio_avm_req_t avm_req_in,
    input wire fpio_pkg::fpio_drive_t pin_drive_out,
    input wire logic [31:0] avm_readdata_out,
    input wire logic avm_waitrequest_out,
    input wire logic [31:0] pin_level_in,
    input wire fpio_pkg::fpio_periph_en_t periph_en_in,
    input wire fpio_pkg::fpio_drive_t periph_drive_in,
    input wire logic [31:0] periph_pin_level_out,
    input wire logic [7:0] adc_pin_claim_out,
    input wire logic [7:0] lamp_drive_out
);
    import fpio_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    // ****************************************
    // bus and pin relations
    // ****************************************
    AST_ACK_ONE: assert property ($fell(avm_waitrequest_out) |=> avm_waitrequest_out)
        else $error("ack held longer than one cycle");
    AST_ACK_SOON: assert property ($rose(avm_req_in.read || avm_req_in.write) |=> !avm_waitrequest_out)
        else $error("request not answered after one wait cycle");
    AST_UPPER_ZERO: assert property (!avm_waitrequest_out |-> avm_readdata_out[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_OD_LOW: assert property ((pin_drive_out.level & FPIO_OPEN_DRAIN_MASK) == 32'h0)
        else $error("open-drain pin driven high");
    AST_DIR_RESET: assert property ($rose(arst_n_in) |-> pin_drive_out.enable == 32'h0)
        else $error("pin driven right after reset");
    AST_ADC_CLAIM: assert property (arst_n_in |=> adc_pin_claim_out ==
        ($past(periph_en_in.converter_channel_select) < 5'd8 ?
        (8'h01 << $past(periph_en_in.converter_channel_select)) : 8'h00))
        else $error("converter claim wrong");
    AST_ADC_OFF: assert property ((pin_drive_out.enable[7:0] & adc_pin_claim_out) == 8'h0)
        else $error("converter pin still driven");
    AST_LAMP: assert property ((lamp_drive_out & adc_pin_claim_out) == 8'h0)
        else $error("lamp drive on converter pin");
    AST_KEYPAD: assert property (arst_n_in |=> ((pin_drive_out.enable[31:24] ^
        $past(periph_drive_in.enable[31:24])) & $past(periph_en_in.keypad_input_enable_bits)) == 8'h0)
        else $error("keypad pin not under peripheral control");
    AST_PIN_FWD: assert property (arst_n_in |=> periph_pin_level_out == $past(pin_level_in))
        else $error("pin level not forwarded to peripherals");
endmodule

// [fpio_pin_model.sv]
// resolves the 32 pad wires from the block's drive and the outside world
// assumes open-drain pins carry a board pull-up; other idle pins show ext_level_in
`timescale 1ns/1ps
module fpio_pin_model (
    input wire fpio_pkg::fpio_drive_t drive_in,
    input wire logic [31:0] ext_level_in,
    output logic [31:0] pin_level_out
);
    import fpio_pkg::*;
    always_comb begin
        for (int i = 0; i < FPIO_PINS; i++) begin
            if (drive_in.enable[i]) begin
                pin_level_out[i] = drive_in.level[i];
            end else if (FPIO_OPEN_DRAIN_MASK[i]) begin
                pin_level_out[i] = 1'b1;
            end else begin
                pin_level_out[i] = ext_level_in[i];
            end
        end
    end
endmodule

// [four_port_parallel_io_tb.sv]
// self-checking bench for the four-port io block over avalon-mm
// assumes fpio_top, fpio_pin_model and fpio_checker are compiled before it
`timescale 1ns/1ps
module four_port_parallel_io_tb;
    import fpio_pkg::*;
    logic clk_in;
    logic arst_n_in;
    fpio_avm_req_t req;
    fpio_drive_t pin_drive;
    fpio_drive_t periph_drive;
    fpio_periph_en_t periph_en;
    logic [31:0] rdata, pin_level, ext_level, fwd_level, rv;
    logic wait_req;
    logic [7:0] claim, lamp, ext_b, od;
    int miscompares, num_checks, cyc;

    fpio_top dut_u (.clk_in, .arst_n_in, .avm_req_in(req), .pin_drive_out(pin_drive),
        .avm_readdata_out(rdata), .avm_waitrequest_out(wait_req), .pin_level_in(pin_level),
        .periph_en_in(periph_en), .periph_drive_in(periph_drive),
        .periph_pin_level_out(fwd_level), .adc_pin_claim_out(claim), .lamp_drive_out(lamp));
    fpio_pin_model pins_u (.drive_in(pin_drive), .ext_level_in(ext_level),
        .pin_level_out(pin_level));

    // ****************************************
    // bus tasks and verdict
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [3:0] idx, input logic [7:0] d);
        @(posedge clk_in);
        req.read <= !wr;
        req.write <= wr;
        req.address <= {idx, 2'b00};
        req.writedata <= {24'h0, d};
        do begin
            @(posedge clk_in);
        end while (wait_req !== 1'b0);
        rv = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
        acc(1'b0, idx, 8'h00);
        chk(rv, {24'h0, exp});
    endtask
    task finish_test;
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // the whole run needs about 130 cycles
    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 3000) begin
            miscompares++;
            $display("BAD %0t timeout", $time);
            finish_test();
        end
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        arst_n_in = 1'b0;
        req = '0;
        req.byteenable = 4'hf;
        periph_en = '0;
        periph_en.second_ext_interrupt_mask = 1'b1;
        periph_en.converter_channel_select = 5'h1f;
        periph_drive = '0;
        ext_level = 32'h9663_a53c;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        for (int i = 4; i < 8; i++) rd(4'(i), 8'h00);
        rd(4'hc, 8'h00);
        for (int p = 0; p < 4; p++) begin
            od = FPIO_OPEN_DRAIN_MASK[8*p +: 8];
            ext_b = ext_level[8*p +: 8] | od;
            acc(1'b1, 4'(p), 8'h5a);
            rd(4'(p), ext_b);
            acc(1'b1, 4'(p + 4), 8'h0f);
            rd(4'(p), (8'h5a & 8'h0f) | (ext_b & 8'hf0));
            acc(1'b1, 4'(p + 4), 8'hff);
            rd(4'(p), 8'h5a);
            repeat (3) @(posedge clk_in);
            chk(pin_drive.enable[8*p +: 8], 8'(~(8'h5a & od)));
            chk(pin_drive.level[8*p +: 8], 8'h5a & ~od);
        end
        acc(1'b1, 4'h8, 8'hff);
        rd(4'h8, 8'h00);
        acc(1'b1, 4'hc, 8'hff);
        rd(4'hc, 8'hff);
        req.byteenable <= 4'he;
        acc(1'b1, 4'hc, 8'h00);
        req.byteenable <= 4'hf;
        rd(4'hc, 8'hff);
        periph_en.converter_channel_select <= 5'd3;
        periph_en.keypad_input_enable_bits <= 8'hff;
        periph_en.two_wire_serial_enable <= 1'b1;
        periph_drive.enable <= 32'h0f00_0300;
        periph_drive.level <= 32'h3c00_0200;
        repeat (3) @(posedge clk_in);
        chk(claim, 8'h08);
        chk(lamp, 8'hf7);
        chk(pin_drive.enable[7:0], 8'hf7);
        chk(pin_drive.enable[31:24], 8'h0f);
        chk(pin_drive.level[31:24], 8'h3c);
        chk(pin_drive.enable[9:8], 2'b01);
        rd(4'h3, 8'h5a);
        // mid-run reset: directions clear, latches survive
        arst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        rd(4'h5, 8'h00);
        acc(1'b1, 4'h5, 8'hff);
        rd(4'h1, 8'h5a);
        finish_test();
    end
endmodule

bind fpio_top fpio_checker chk_u (.clk_in, .arst_n_in, .avm_req_in, .pin_drive_out,
    .avm_readdata_out, .avm_waitrequest_out, .pin_level_in, .periph_en_in, .periph_drive_in,
    .periph_pin_level_out, .adc_pin_claim_out, .lamp_drive_out);
